// *** ccmc_pkg.sv ***
/*
  Constants for the channel mode configuration block: register map,
  field positions, reset values and code points.
  Assumes a 32-bit AHB-Lite register bus and a 16-bit timer counter.
*/
`default_nettype none
package ccmc_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  MODE_OFFSET   = 8'h18;
  localparam logic [7:0]  CMP_OFFSET    = 8'h34;
  localparam logic [7:0]  STATUS_OFFSET = 8'h40;
  localparam logic [15:0] MODE_RESET    = 16'h0000;
  localparam logic [15:0] CMP_RESET     = 16'h0000;
  // ---------------------------------------------------------------
  // Mode register field positions
  // ---------------------------------------------------------------
  localparam int CH1_DIR_LSB     = 0;
  localparam int CH1_FAST_BIT    = 2;
  localparam int CH1_PRELOAD_BIT = 3;
  localparam int CH1_MODE_LSB    = 4;
  localparam int CH1_CLEAR_BIT   = 7;
  localparam int CH1_CAP_LSB     = 2;
  localparam int CH2_DIR_LSB     = 8;
  localparam int CH2_CAP_LSB     = 10;
  localparam int CAP_WIDTH       = 6;
  // ---------------------------------------------------------------
  // Direction select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] DIR_OUTPUT    = 2'h0;
  localparam logic [1:0] DIR_IN_OWN    = 2'h1;
  localparam logic [1:0] DIR_IN_OTHER  = 2'h2;
  localparam logic [1:0] DIR_IN_TRIG   = 2'h3;
  // ---------------------------------------------------------------
  // Compare mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CM_FROZEN     = 3'h0;
  localparam logic [2:0] CM_SET_HIGH   = 3'h1;
  localparam logic [2:0] CM_SET_LOW    = 3'h2;
  localparam logic [2:0] CM_TOGGLE     = 3'h3;
  localparam logic [2:0] CM_FORCE_LOW  = 3'h4;
  localparam logic [2:0] CM_FORCE_HIGH = 3'h5;
  localparam logic [2:0] CM_PWM1       = 3'h6;
  localparam logic [2:0] CM_PWM2       = 3'h7;
endpackage : ccmc_pkg
`default_nettype wire

// *** ccmc_channel_mode.sv ***
/*
  Capture/compare channel 1 and 2 mode configuration with the channel 1
  compare reference generator, behind an AHB-Lite slave.
  Assumes counter, update event, trigger edge and enables come from the
  surrounding timer, synchronous to clk.
*/
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Direction field picks capture or compare
// - Other bits decoded per current direction
// - Channel 2 direction locked while enabled
// - Clear enable lets high trigger clear reference
// - Channel 2 input mapping; trigger needs selection
// - PWM reference moves on compare change or when leaving frozen
// - Preload routes compare writes via shadow
// - Fast enable: trigger edge acts as match in PWM modes only
module ccmc_channel_mode
  import ccmc_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output var  logic          hreadyout,
  output var  logic          hresp,
  output var  logic [31:0]   hrdata,
  input  wire logic [CW-1:0] counterValue,
  input  wire logic          countDown,
  input  wire logic          updateEvent,
  input  wire logic          ch2OutputEnable,
  input  wire logic          filteredExternalTrigger,
  input  wire logic          triggerEdge,
  input  wire logic          triggerSourceInternal,
  input  wire logic          timerInputOne,
  input  wire logic          timerInputTwo,
  input  wire logic          internalTriggerCaptureInput,
  output var  logic          ch1OutputReference,
  output var  logic          ch1CaptureInput,
  output var  logic          ch2CaptureInput,
  output var  logic          ch1IsOutput,
  output var  logic          ch2IsOutput,
  output var  logic [5:0]    ch1CaptureSettings,
  output var  logic [5:0]    ch2CaptureSettings
);
  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic mapInput(input logic [1:0] dir,
                                    input logic own,
                                    input logic other,
                                    input logic trig,
                                    input logic trigOk);
    case (dir)
      DIR_IN_OWN:   mapInput = own;
      DIR_IN_OTHER: mapInput = other;
      DIR_IN_TRIG:  mapInput = trig & trigOk;
      default:      mapInput = 1'b0;
    endcase
  endfunction : mapInput

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [15:0]   mode_q;
  logic [CW-1:0] cmpShadow_q;
  logic [CW-1:0] cmpActive_q;
  logic          wrPend_q;
  logic [7:0]    wrAddr_q;
  logic [31:0]   rdData_d;
  logic          ref_q;
  logic          ref_d;
  logic          pwmHigh_q;
  logic [2:0]    modePrev_q;

  wire        addrPhase = hsel & htrans[1] & hready;
  wire [7:0]  addrLow   = haddr[7:0];
  wire        wrMode    = wrPend_q & (wrAddr_q == MODE_OFFSET);
  wire        wrCmp     = wrPend_q & (wrAddr_q == CMP_OFFSET);
  wire [15:0] cmpActiveWide = 16'(cmpActive_q);
  wire [31:0] statusWord = {cmpActiveWide,
                            11'h000, ch2CaptureInput, ch1CaptureInput,
                            ch2IsOutput, ch1IsOutput, ref_q};

  always_comb begin
    case (addrLow)
      MODE_OFFSET:   rdData_d = {16'h0000, mode_q};
      CMP_OFFSET:    rdData_d = {{(32-CW){1'b0}}, cmpShadow_q};
      STATUS_OFFSET: rdData_d = statusWord;
      default:       rdData_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q  <= 1'b0;
      wrAddr_q  <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      wrPend_q  <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_q <= addrLow;
        hrdata   <= hwrite ? 32'h00000000 : rdData_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------
  wire [1:0]  ch1Dir      = mode_q[CH1_DIR_LSB +: 2];
  wire [1:0]  ch2Dir      = mode_q[CH2_DIR_LSB +: 2];
  wire [1:0]  ch2DirNext  = ch2OutputEnable ? ch2Dir
                          : hwdata[CH2_DIR_LSB +: 2];
  wire [15:0] modeWrite   = {hwdata[15:10], ch2DirNext, hwdata[7:0]};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_RESET;
    end else if (wrMode) begin
      mode_q <= modeWrite;
    end
  end

  // ---------------------------------------------------------------
  // Direction and per-direction decode
  // ---------------------------------------------------------------
  wire ch1Out = (ch1Dir == DIR_OUTPUT);
  wire ch2Out = (ch2Dir == DIR_OUTPUT);
  wire [2:0] ch1Mode    = ch1Out ? mode_q[CH1_MODE_LSB +: 3]
                        : CM_FROZEN;
  wire       ch1Fast    = ch1Out & mode_q[CH1_FAST_BIT];
  wire       ch1Preload = ch1Out & mode_q[CH1_PRELOAD_BIT];
  wire       ch1ClearEn = ch1Out & mode_q[CH1_CLEAR_BIT];
  wire [5:0] ch1Cap = ch1Out ? 6'h00
                    : mode_q[CH1_CAP_LSB +: CAP_WIDTH];
  wire [5:0] ch2Cap = ch2Out ? 6'h00
                    : mode_q[CH2_CAP_LSB +: CAP_WIDTH];
  wire ch1In = mapInput(ch1Dir, timerInputOne, timerInputTwo,
                        internalTriggerCaptureInput,
                        triggerSourceInternal);
  wire ch2In = mapInput(ch2Dir, timerInputTwo, timerInputOne,
                        internalTriggerCaptureInput,
                        triggerSourceInternal);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch1IsOutput        <= 1'b1;
      ch2IsOutput        <= 1'b1;
      ch1CaptureInput    <= 1'b0;
      ch2CaptureInput    <= 1'b0;
      ch1CaptureSettings <= 6'h00;
      ch2CaptureSettings <= 6'h00;
    end else begin
      ch1IsOutput        <= ch1Out;
      ch2IsOutput        <= ch2Out;
      ch1CaptureInput    <= ch1In;
      ch2CaptureInput    <= ch2In;
      ch1CaptureSettings <= ch1Cap;
      ch2CaptureSettings <= ch2Cap;
    end
  end

  // ---------------------------------------------------------------
  // Compare value with preload
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmpShadow_q <= CMP_RESET[CW-1:0];
      cmpActive_q <= CMP_RESET[CW-1:0];
    end else begin
      if (wrCmp) begin
        cmpShadow_q <= hwdata[CW-1:0];
      end
      if (wrCmp && !ch1Preload) begin
        cmpActive_q <= hwdata[CW-1:0];
      end else if (updateEvent && ch1Preload) begin
        cmpActive_q <= cmpShadow_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reference generator
  // ---------------------------------------------------------------
  logic matchPrev_q;
  wire  match     = (counterValue == cmpActive_q);
  wire  matchRise = match & ~matchPrev_q;
  wire  pwmHigh   = countDown ? (counterValue <= cmpActive_q)
                  : (counterValue < cmpActive_q);
  wire  isPwm     = (ch1Mode == CM_PWM1) | (ch1Mode == CM_PWM2);
  wire  pwmLevel  = (ch1Mode == CM_PWM1) ? pwmHigh : ~pwmHigh;
  wire  pwmMove   = (pwmHigh != pwmHigh_q)
                  | (modePrev_q == CM_FROZEN);
  wire  fastHit   = ch1Fast & triggerEdge;
  wire  clearHit  = ch1ClearEn & filteredExternalTrigger;

  always_comb begin
    ref_d = ref_q;
    if (!ch1Out) begin
      ref_d = 1'b0;
    end else if (clearHit) begin
      ref_d = 1'b0;
    end else begin
      case (ch1Mode)
        CM_FROZEN:     ref_d = ref_q;
        CM_SET_HIGH:   ref_d = matchRise ? 1'b1 : ref_q;
        CM_SET_LOW:    ref_d = matchRise ? 1'b0 : ref_q;
        CM_TOGGLE:     ref_d = matchRise ? ~ref_q : ref_q;
        CM_FORCE_LOW:  ref_d = 1'b0;
        CM_FORCE_HIGH: ref_d = 1'b1;
        default: begin
          if (fastHit) begin
            ref_d = (ch1Mode == CM_PWM1);
          end else if (pwmMove) begin
            ref_d = pwmLevel;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_q       <= 1'b0;
      matchPrev_q <= 1'b0;
      pwmHigh_q   <= 1'b0;
      modePrev_q  <= CM_FROZEN;
    end else begin
      ref_q       <= ref_d;
      matchPrev_q <= match;
      pwmHigh_q   <= pwmHigh;
      modePrev_q  <= ch1Mode;
    end
  end

  assign ch1OutputReference = ref_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence seqCmpWriteDirect;
    wrCmp && !ch1Preload;
  endsequence
  sequence seqCmpWriteHeld;
    wrCmp && ch1Preload && !updateEvent;
  endsequence
  sequence seqPwmQuiet;
    ch1Out && isPwm && !clearHit && !fastHit
      && (pwmHigh == pwmHigh_q) && (modePrev_q == ch1Mode);
  endsequence

  AST_CH2_DIR_LOCK: assert property (
    wrMode && ch2OutputEnable |=> $stable(mode_q[9:8]))
    else $error("ch2 direction changed while enabled");
  AST_CH2_DIR_WRITE: assert property (
    wrMode && !ch2OutputEnable |=> mode_q[9:8] == $past(hwdata[9:8]))
    else $error("ch2 direction write not taken");
  AST_CLEAR: assert property (
    ch1Out && mode_q[7] && filteredExternalTrigger |=> !ch1OutputReference)
    else $error("reference not cleared by trigger");
  AST_FORCE_HIGH: assert property (
    ch1Out && ch1Mode == CM_FORCE_HIGH && !clearHit
      ##1 ch1Out && ch1Mode == CM_FORCE_HIGH && !clearHit
      |=> ch1OutputReference)
    else $error("force high not held");
  AST_PRELOAD_OFF: assert property (
    seqCmpWriteDirect |=> cmpActive_q == $past(hwdata[CW-1:0]))
    else $error("direct compare write missed");
  AST_PRELOAD_ON: assert property (
    seqCmpWriteHeld |=> $stable(cmpActive_q))
    else $error("preloaded write reached active value");
  AST_PWM_HOLD: assert property (
    seqPwmQuiet |=> ch1OutputReference == $past(ch1OutputReference))
    else $error("pwm reference moved without cause");
  AST_FAST: assert property (
    ch1Out && ch1Mode == CM_PWM2 && fastHit && !clearHit
      |=> !ch1OutputReference)
    else $error("fast trigger did not act as match");
  AST_TRIG_MAP: assert property (
    ch2Dir == DIR_IN_TRIG && !triggerSourceInternal |=> !ch2CaptureInput)
    else $error("trigger mapping used without selection");
  AST_INPUT_IDLE: assert property (
    !ch1Out |=> !ch1OutputReference && !ch1IsOutput)
    else $error("input channel drives reference");
endmodule : ccmc_channel_mode
`default_nettype wire

// *** ccmc_channel_mode_tb.sv ***
/*
  Self-checking bench for the channel mode configuration block.
  Assumes ccmc_pkg and ccmc_channel_mode are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module ccmc_channel_mode_tb;
  import ccmc_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  wire  logic  hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] counterValue = 16'h0000;
  logic        countDown = 1'b0;
  logic        updateEvent = 1'b0;
  logic        ch2OutputEnable = 1'b0;
  logic        filteredExternalTrigger = 1'b0;
  logic        triggerEdge = 1'b0;
  logic        triggerSourceInternal = 1'b0;
  logic        timerInputOne = 1'b0;
  logic        timerInputTwo = 1'b0;
  logic        internalTriggerCaptureInput = 1'b0;
  logic        ch1OutputReference;
  logic        ch1CaptureInput;
  logic        ch2CaptureInput;
  logic        ch1IsOutput;
  logic        ch2IsOutput;
  logic [5:0]  ch1CaptureSettings;
  logic [5:0]  ch2CaptureSettings;
  logic [31:0] rdata;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  // Mode step: mode, counter, bit1 count down, bit0 expected reference
  localparam logic [11:0] STEPS [17] = '{12'h501, 12'h400, 12'h151,
    12'h201, 12'h250, 12'h300, 12'h351, 12'h450, 12'h020, 12'h621,
    12'h670, 12'h070, 12'h771, 12'h720, 12'h052, 12'h653, 12'h662};

  assign hready = hreadyout;
  always #2 clk = ~clk;

  ccmc_channel_mode uut (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .counterValue(counterValue), .countDown(countDown),
    .updateEvent(updateEvent), .ch2OutputEnable(ch2OutputEnable),
    .filteredExternalTrigger(filteredExternalTrigger),
    .triggerEdge(triggerEdge),
    .triggerSourceInternal(triggerSourceInternal),
    .timerInputOne(timerInputOne), .timerInputTwo(timerInputTwo),
    .internalTriggerCaptureInput(internalTriggerCaptureInput),
    .ch1OutputReference(ch1OutputReference),
    .ch1CaptureInput(ch1CaptureInput), .ch2CaptureInput(ch2CaptureInput),
    .ch1IsOutput(ch1IsOutput), .ch2IsOutput(ch2IsOutput),
    .ch1CaptureSettings(ch1CaptureSettings),
    .ch2CaptureSettings(ch2CaptureSettings)
  );
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask : xfer
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    xfer(1'b0, MODE_OFFSET, 32'h00000000);
    `CHK(rdata, 32'h00000000)
    xfer(1'b0, STATUS_OFFSET, 32'h00000000);
    `CHK(rdata, 32'h00000006)
    xfer(1'b1, 8'h20, 32'hFFFFFFFF);
    xfer(1'b0, 8'h20, 32'h00000000);
    `CHK(rdata, 32'h00000000)
    `CHK(hresp, 1'b0)
  endtask : t_reset

  task automatic t_dir();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      triggerSourceInternal       <= 1'b1;
      timerInputOne               <= (c == DIR_IN_OTHER);
      timerInputTwo               <= (c == DIR_IN_OWN);
      internalTriggerCaptureInput <= (c == DIR_IN_TRIG);
      xfer(1'b1, MODE_OFFSET, {16'h0000, 6'h2A, c, 8'h00});
      tick(3);
      `CHK(ch2IsOutput, (c == DIR_OUTPUT))
      `CHK(ch2CaptureSettings, (c == DIR_OUTPUT) ? 6'h00 : 6'h2A)
      `CHK(ch2CaptureInput, (c != DIR_OUTPUT))
      timerInputOne               <= (c != DIR_IN_OTHER);
      timerInputTwo               <= (c != DIR_IN_OWN);
      internalTriggerCaptureInput <= (c != DIR_IN_TRIG);
      tick(3);
      `CHK(ch2CaptureInput, 1'b0)
    end
    triggerSourceInternal       <= 1'b0;
    internalTriggerCaptureInput <= 1'b1;
    tick(3);
    `CHK(ch2CaptureInput, 1'b0)
    timerInputOne <= 1'b1;
    xfer(1'b1, MODE_OFFSET, 32'h00000005);
    tick(3);
    `CHK(ch1IsOutput, 1'b0)
    `CHK(ch1CaptureSettings, 6'h01)
    `CHK(ch1CaptureInput, 1'b1)
  endtask : t_dir

  task automatic t_lock();
    xfer(1'b1, MODE_OFFSET, 32'h00000100);
    ch2OutputEnable <= 1'b1;
    xfer(1'b1, MODE_OFFSET, 32'h00000250);
    xfer(1'b0, MODE_OFFSET, 32'h00000000);
    `CHK(rdata, 32'h00000150)
    ch2OutputEnable <= 1'b0;
    xfer(1'b1, MODE_OFFSET, 32'h00000250);
    xfer(1'b0, MODE_OFFSET, 32'h00000000);
    `CHK(rdata, 32'h00000250)
  endtask : t_lock

  task automatic t_modes();
    logic [11:0] s;
    xfer(1'b1, MODE_OFFSET, 32'h00000000);
    xfer(1'b1, CMP_OFFSET, 32'h00000005);
    for (int i = 0; i < 17; i++) begin
      s = STEPS[i];
      xfer(1'b1, MODE_OFFSET, {25'h0000000, s[10:8], 4'h0});
      counterValue <= {12'h000, s[7:4]};
      countDown    <= s[1];
      tick(3);
      `CHK(ch1OutputReference, s[0])
    end
    countDown <= 1'b0;
  endtask : t_modes

  task automatic t_clear();
    xfer(1'b1, MODE_OFFSET, 32'h00000050);
    filteredExternalTrigger <= 1'b1;
    tick(3);
    `CHK(ch1OutputReference, 1'b1)
    xfer(1'b1, MODE_OFFSET, 32'h000000D0);
    tick(3);
    `CHK(ch1OutputReference, 1'b0)
    filteredExternalTrigger <= 1'b0;
    tick(3);
    `CHK(ch1OutputReference, 1'b1)
  endtask : t_clear

  task automatic t_preload();
    xfer(1'b1, MODE_OFFSET, 32'h00000000);
    xfer(1'b1, CMP_OFFSET, 32'h00000011);
    xfer(1'b0, STATUS_OFFSET, 32'h00000000);
    `CHK(rdata[31:16], 16'h0011)
    xfer(1'b1, MODE_OFFSET, 32'h00000008);
    xfer(1'b1, CMP_OFFSET, 32'h00000022);
    xfer(1'b0, STATUS_OFFSET, 32'h00000000);
    `CHK(rdata[31:16], 16'h0011)
    xfer(1'b0, CMP_OFFSET, 32'h00000000);
    `CHK(rdata, 32'h00000022)
    updateEvent <= 1'b1;
    tick(1);
    updateEvent <= 1'b0;
    tick(2);
    xfer(1'b0, STATUS_OFFSET, 32'h00000000);
    `CHK(rdata[31:16], 16'h0022)
  endtask : t_preload

  task automatic t_fast();
    xfer(1'b1, MODE_OFFSET, 32'h00000000);
    xfer(1'b1, CMP_OFFSET, 32'h00000005);
    counterValue <= 16'h0009;
    xfer(1'b1, MODE_OFFSET, 32'h00000064);
    tick(3);
    `CHK(ch1OutputReference, 1'b0)
    triggerEdge <= 1'b1;
    tick(1);
    triggerEdge <= 1'b0;
    tick(2);
    `CHK(ch1OutputReference, 1'b1)
    xfer(1'b1, MODE_OFFSET, 32'h00000074);
    tick(3);
    `CHK(ch1OutputReference, 1'b1)
    triggerEdge <= 1'b1;
    tick(1);
    triggerEdge <= 1'b0;
    tick(2);
    `CHK(ch1OutputReference, 1'b0)
  endtask : t_fast
  // ---------------------------------------------------------------
  // Sequence and timeout
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_dir();
    t_lock();
    t_modes();
    t_clear();
    t_preload();
    t_fast();
    complete_run();
  end
endmodule : ccmc_channel_mode_tb
`default_nettype wire
